// ==== rwsi_params.svh ====
// Register offsets, reset values and timing counts of the reset and wake-up state logic
`ifndef RWSI_PARAMS_SVH
`define RWSI_PARAMS_SVH

`define RWSI_OFS_INDIRECT_DATA_PORT     8'h00
`define RWSI_OFS_TMR      8'h01
`define RWSI_OFS_PCL      8'h02
`define RWSI_OFS_STATUS   8'h03
`define RWSI_OFS_PTR      8'h04
`define RWSI_OFS_PA       8'h05
`define RWSI_OFS_PB       8'h06
`define RWSI_OFS_PROGRAM_COUNTER_HIGH_LATCH   8'h0A
`define RWSI_OFS_INTERRUPT_CONTROL   8'h0B
`define RWSI_OFS_OPTION   8'h81
`define RWSI_OFS_DIRA     8'h85
`define RWSI_OFS_DIRB     8'h86
`define RWSI_OFS_PWRCTL   8'h8E

`define RWSI_RST_STATUS   8'h18
`define RWSI_RST_OPTION   8'hFF
`define RWSI_RST_DIRA     5'h1F
`define RWSI_RST_DIRB     8'hFF
`define RWSI_RST_PROGRAM_COUNTER_HIGH_LATCH   5'h00
`define RWSI_RST_PC       13'h0000
`define RWSI_INT_VECTOR   13'h0004

`define RWSI_BIT_GIE      7
`define RWSI_BIT_TO       4
`define RWSI_BIT_PD       3
`define RWSI_BIT_PORFLAG  1

// Core clock is divided by four into one instruction cycle
`define RWSI_INSTR_CLKS   2'd3

`endif

// ==== rwsi_pkg.sv ====
// Types shared by the reset and wake-up state logic
package rwsi_pkg;

   typedef enum logic [1:0] {
      RWSI_RUN,
      RWSI_SLEEP,
      RWSI_VEC_WAIT
   } rwsi_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rwsi_bus_req_t;

   typedef struct packed {
      rwsi_mode_t  mode;
      logic [12:0] pc;
      logic [12:0] ret_addr;
      logic        push;
      logic [1:0]  vec_cnt;
      logic [7:0]  status;
      logic [7:0]  interrupt_control;
      logic [7:0]  option;
      logic [7:0]  tmr;
      logic [7:0]  ptr;
      logic [7:0]  pin_group_b_data;
      logic [7:0]  dirb;
      logic [4:0]  pin_group_a_data;
      logic [4:0]  dira;
      logic [4:0]  program_counter_high_latch;
      logic        por_flag;
      // Sleep level as its own flop so the output needs no decode
      logic        sleeping;
      logic [7:0]  rdata;
   } rwsi_state_t;

endpackage : rwsi_pkg

// ==== rwsi_reset_state.sv ====
// Special register set with per-cause reset and wake-up initialisation
//
// Function
// RL1: An external reset while running zeroes the PC, clears status bits 7:5 and keeps the rest and the power flag.
// RL2: An external reset during sleep zeroes the PC, sets status 7:4 to 0001, clears bit 3 and keeps bits 2:0.
// RL3: An interrupt wake-up resumes at PC plus one and leaves other registers alone apart from status and flags.
// RL4: An interrupt wake-up with the global enable set runs the next instruction and then jumps to the vector.
// RL5: A watchdog wake-up resumes at PC plus one, clears status bits 4 and 3 and keeps everything else.
// RL6: On an interrupt wake-up the flag bits that caused it stay set and the rest of the control register holds.
// RL7: Status bits 4 and 3 take per-cause values while the upper bits follow the cause pattern and the lower keep.
// RL8: Unimplemented bits of the initialised registers always read as zero.
// RL9: Every reset sets option and direction registers to ones and clears PC low and high latch; wake-ups do not.
// RL10: Every reset clears the global interrupt enable.
// RL11: Servicing an interrupt clears the global enable, pushes the return address and loads the vector.
// RL12: Status bit 4 is the timeout flag cleared by watchdog events, bit 3 the power-down flag cleared on sleep.
`timescale 1ns/100ps
`include "rwsi_params.svh"
module rwsi_reset_state
   import rwsi_pkg::*;
(
   input  wire logic          ref_clk_i,
   input  wire logic          reset_i,
   input  wire logic          external_reset_pin_n_i,
   input  wire logic          watchdog_timer_timeout_i,
   input  wire logic          sleep_enter_i,
   input  wire logic          pc_step_i,
   input  wire logic [2:0]    int_flag_set_i,
   input  wire rwsi_bus_req_t bus_i,
   output logic      [7:0]    rdata_o,
   output logic      [12:0]   pc_o,
   output logic      [7:0]    cpu_status_flags_o,
   output logic      [7:0]    interrupt_control_o,
   output logic      [7:0]    option_settings_o,
   output logic      [4:0]    pin_group_a_direction_o,
   output logic      [7:0]    pin_group_b_direction_o,
   output logic      [4:0]    pin_group_a_data_o,
   output logic      [7:0]    pin_group_b_data_o,
   output logic               sleeping_o,
   output logic               stack_push_o,
   output logic      [12:0]   return_addr_o
);
   rwsi_state_t s_reg;
   rwsi_state_t s_next;
   logic        pin_n_sync;
   logic        ext_rst;
   logic        wake_pending;
   logic        global_interrupt_enable;

   rwsi_sync2 #(
      .W       (1),
      .RST_VAL (1'b1)
   ) u_pin_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .async_i   (external_reset_pin_n_i),
      .sync_o    (pin_n_sync)
   );

   assign ext_rst      = ~pin_n_sync;
   assign global_interrupt_enable          = s_reg.interrupt_control[`RWSI_BIT_GIE];
   // Enables in bits 5:3 line up with flags in bits 2:0
   assign wake_pending = |(s_reg.interrupt_control[2:0] & s_reg.interrupt_control[5:3]);

   // Register values shared by every reset cause
   function automatic rwsi_state_t apply_reset(input rwsi_state_t st);
      rwsi_state_t r;
      r         = st;
      r.mode    = RWSI_RUN;
      r.pc      = `RWSI_RST_PC;
      r.program_counter_high_latch  = `RWSI_RST_PROGRAM_COUNTER_HIGH_LATCH; // RL9
      r.option  = `RWSI_RST_OPTION; // RL9
      r.dira    = `RWSI_RST_DIRA; // RL9
      r.dirb    = `RWSI_RST_DIRB; // RL9
      r.interrupt_control  = {7'h00, st.interrupt_control[0]}; // RL10
      r.vec_cnt = 2'd0;
      return r;
   endfunction : apply_reset

   always_comb begin
      logic rst_hit;
      rst_hit      = 1'b0;
      s_next       = s_reg;
      s_next.push  = 1'b0;
      s_next.rdata = 8'h00;

      // Read data for the previous-cycle strobe; unmapped offsets read zero
      if (bus_i.rd) begin
         if (bus_i.addr == `RWSI_OFS_TMR) begin
            s_next.rdata = s_reg.tmr;
         end else if (bus_i.addr == `RWSI_OFS_PCL) begin
            s_next.rdata = s_reg.pc[7:0];
         end else if (bus_i.addr == `RWSI_OFS_STATUS) begin
            s_next.rdata = s_reg.status;
         end else if (bus_i.addr == `RWSI_OFS_PTR) begin
            s_next.rdata = s_reg.ptr;
         end else if (bus_i.addr == `RWSI_OFS_PA) begin
            s_next.rdata = {3'b000, s_reg.pin_group_a_data}; // RL8
         end else if (bus_i.addr == `RWSI_OFS_PB) begin
            s_next.rdata = s_reg.pin_group_b_data;
         end else if (bus_i.addr == `RWSI_OFS_PROGRAM_COUNTER_HIGH_LATCH) begin
            s_next.rdata = {3'b000, s_reg.program_counter_high_latch}; // RL8
         end else if (bus_i.addr == `RWSI_OFS_INTERRUPT_CONTROL) begin
            s_next.rdata = s_reg.interrupt_control;
         end else if (bus_i.addr == `RWSI_OFS_OPTION) begin
            s_next.rdata = s_reg.option;
         end else if (bus_i.addr == `RWSI_OFS_DIRA) begin
            s_next.rdata = {3'b000, s_reg.dira}; // RL8
         end else if (bus_i.addr == `RWSI_OFS_DIRB) begin
            s_next.rdata = s_reg.dirb;
         end else if (bus_i.addr == `RWSI_OFS_PWRCTL) begin
            s_next.rdata = {6'h00, s_reg.por_flag, 1'b0}; // RL8
         end else begin
            s_next.rdata = 8'h00;
         end
      end

      if (ext_rst) begin
         // Held pin keeps reapplying; both patterns are stable under repeat
         rst_hit = 1'b1;
         s_next  = apply_reset(s_next);
         if (s_reg.mode == RWSI_SLEEP) begin
            s_next.status = {4'b0001, 1'b0, s_reg.status[2:0]}; // RL2 RL7
         end else begin
            s_next.status = {3'b000, s_reg.status[4:0]}; // RL1 RL7
         end
      end else if (watchdog_timer_timeout_i) begin
         if (s_reg.mode == RWSI_SLEEP) begin
            s_next.mode   = RWSI_RUN;
            s_next.pc     = s_reg.pc + 13'd1; // RL5
            s_next.status = {s_reg.status[7:5], 2'b00, s_reg.status[2:0]}; // RL5 RL12
         end else begin
            rst_hit       = 1'b1;
            s_next        = apply_reset(s_next);
            s_next.status = {4'b0000, s_reg.status[3:0]}; // RL7 RL12
         end
      end else if (s_reg.mode == RWSI_SLEEP && wake_pending) begin
         s_next.pc     = s_reg.pc + 13'd1; // RL3
         s_next.status = {s_reg.status[7:5], 2'b10, s_reg.status[2:0]}; // RL3 RL7
         // Flags are left as they are so the cause stays visible
         s_next.vec_cnt = 2'd0;
         s_next.mode    = global_interrupt_enable ? RWSI_VEC_WAIT : RWSI_RUN; // RL4
      end else begin
         if (bus_i.wr) begin
            if (bus_i.addr == `RWSI_OFS_TMR) begin
               s_next.tmr = bus_i.wdata;
            end else if (bus_i.addr == `RWSI_OFS_PCL) begin
               s_next.pc = {s_reg.program_counter_high_latch, bus_i.wdata};
            end else if (bus_i.addr == `RWSI_OFS_STATUS) begin
               // Timeout and power-down flags are not software writable
               s_next.status = {bus_i.wdata[7:5], s_reg.status[4:3], bus_i.wdata[2:0]};
            end else if (bus_i.addr == `RWSI_OFS_PTR) begin
               s_next.ptr = bus_i.wdata;
            end else if (bus_i.addr == `RWSI_OFS_PA) begin
               s_next.pin_group_a_data = bus_i.wdata[4:0];
            end else if (bus_i.addr == `RWSI_OFS_PB) begin
               s_next.pin_group_b_data = bus_i.wdata;
            end else if (bus_i.addr == `RWSI_OFS_PROGRAM_COUNTER_HIGH_LATCH) begin
               s_next.program_counter_high_latch = bus_i.wdata[4:0];
            end else if (bus_i.addr == `RWSI_OFS_INTERRUPT_CONTROL) begin
               s_next.interrupt_control = bus_i.wdata;
            end else if (bus_i.addr == `RWSI_OFS_OPTION) begin
               s_next.option = bus_i.wdata;
            end else if (bus_i.addr == `RWSI_OFS_DIRA) begin
               s_next.dira = bus_i.wdata[4:0];
            end else if (bus_i.addr == `RWSI_OFS_DIRB) begin
               s_next.dirb = bus_i.wdata;
            end else if (bus_i.addr == `RWSI_OFS_PWRCTL) begin
               s_next.por_flag = bus_i.wdata[`RWSI_BIT_PORFLAG];
            end
         end

         case (s_reg.mode)
            RWSI_RUN: begin
               if (sleep_enter_i) begin
                  s_next.mode                = RWSI_SLEEP;
                  s_next.status[`RWSI_BIT_PD] = 1'b0; // RL12
                  s_next.status[`RWSI_BIT_TO] = 1'b1;
               end else if (global_interrupt_enable && wake_pending) begin
                  s_next.push                  = 1'b1; // RL11
                  s_next.ret_addr              = s_reg.pc;
                  s_next.pc                    = `RWSI_INT_VECTOR;
                  s_next.interrupt_control[`RWSI_BIT_GIE] = 1'b0;
               end else if (pc_step_i) begin
                  s_next.pc = s_reg.pc + 13'd1;
               end
            end
            RWSI_VEC_WAIT: begin
               // One instruction cycle at the next address, then the vector
               if (s_reg.vec_cnt == `RWSI_INSTR_CLKS) begin
                  s_next.mode                  = RWSI_RUN;
                  s_next.push                  = 1'b1; // RL4 RL11
                  s_next.ret_addr              = s_reg.pc;
                  s_next.pc                    = `RWSI_INT_VECTOR;
                  s_next.interrupt_control[`RWSI_BIT_GIE] = 1'b0;
               end else begin
                  s_next.vec_cnt = s_reg.vec_cnt + 2'd1;
               end
            end
            default: begin
               s_next.mode = s_reg.mode;
            end
         endcase
      end

      // Hardware set beats any same-cycle clear by software
      if (!rst_hit) begin
         s_next.interrupt_control[2:0] = s_next.interrupt_control[2:0] | int_flag_set_i; // RL6
      end
      s_next.sleeping = (s_next.mode == RWSI_SLEEP);
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_reg          <= '0;
         s_reg.mode     <= RWSI_RUN;
         s_reg.status   <= `RWSI_RST_STATUS;
         s_reg.option   <= `RWSI_RST_OPTION; // RL9
         s_reg.dira     <= `RWSI_RST_DIRA;
         s_reg.dirb     <= `RWSI_RST_DIRB;
         s_reg.pc       <= `RWSI_RST_PC;
         s_reg.por_flag <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata_o                 = s_reg.rdata;
   assign pc_o                    = s_reg.pc;
   assign cpu_status_flags_o      = s_reg.status;
   assign interrupt_control_o     = s_reg.interrupt_control;
   assign option_settings_o       = s_reg.option;
   assign pin_group_a_direction_o = s_reg.dira;
   assign pin_group_b_direction_o = s_reg.dirb;
   assign pin_group_a_data_o      = s_reg.pin_group_a_data;
   assign pin_group_b_data_o      = s_reg.pin_group_b_data;
   assign sleeping_o              = s_reg.sleeping;
   assign stack_push_o            = s_reg.push;
   assign return_addr_o           = s_reg.ret_addr;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence int_wake_gie_s;
      s_reg.mode == RWSI_SLEEP && !ext_rst && !watchdog_timer_timeout_i && wake_pending && global_interrupt_enable;
   endsequence

   sequence vector_taken_s;
      stack_push_o && pc_o == 13'h0004 && !interrupt_control_o[7];
   endsequence

   run_ext_reset_a: assert property ( // RL1
      ext_rst && s_reg.mode != RWSI_SLEEP |=> cpu_status_flags_o[7:5] == 3'b000 && pc_o == 13'h0000
         && cpu_status_flags_o[4:0] == $past(cpu_status_flags_o[4:0]) && s_reg.por_flag == $past(s_reg.por_flag))
      else $error("external reset while running gave wrong state");
   sleep_ext_reset_a: assert property ( // RL2
      ext_rst && s_reg.mode == RWSI_SLEEP |=> cpu_status_flags_o[7:3] == 5'b00010 && pc_o == 13'h0000
         && cpu_status_flags_o[2:0] == $past(cpu_status_flags_o[2:0]))
      else $error("external reset during sleep gave wrong state");
   int_wake_pc_a: assert property ( // RL3
      s_reg.mode == RWSI_SLEEP && !ext_rst && !watchdog_timer_timeout_i && wake_pending
         |=> pc_o == $past(pc_o) + 13'd1 && cpu_status_flags_o[4:3] == 2'b10
         && option_settings_o == $past(option_settings_o))
      else $error("interrupt wake-up did not resume at next address");
   wake_vector_a: assert property ( // RL4
      int_wake_gie_s |=> !stack_push_o ##[3:4] vector_taken_s)
      else $error("vector not taken one instruction after wake-up");
   wdt_wake_a: assert property ( // RL5
      s_reg.mode == RWSI_SLEEP && !ext_rst && watchdog_timer_timeout_i |=> pc_o == $past(pc_o) + 13'd1
         && cpu_status_flags_o == {$past(cpu_status_flags_o[7:5]), 2'b00, $past(cpu_status_flags_o[2:0])})
      else $error("watchdog wake-up gave wrong state");
   wake_flags_kept_a: assert property ( // RL6
      s_reg.mode == RWSI_SLEEP && !ext_rst && !watchdog_timer_timeout_i && wake_pending
         |=> (interrupt_control_o & $past(interrupt_control_o)) == $past(interrupt_control_o))
      else $error("wake-up cause flag lost");
   wdt_reset_status_a: assert property ( // RL7
      !ext_rst && watchdog_timer_timeout_i && s_reg.mode != RWSI_SLEEP
         |=> cpu_status_flags_o == {4'b0000, $past(cpu_status_flags_o[3:0])})
      else $error("watchdog reset gave wrong status");
   unimpl_zero_a: assert property ( // RL8
      bus_i.rd && (bus_i.addr == 8'h0A || bus_i.addr == 8'h85 || bus_i.addr == 8'h05) |=> rdata_o[7:5] == 3'b000)
      else $error("unimplemented bits read as one");
   reset_defaults_a: assert property ( // RL9
      ext_rst |=> option_settings_o == 8'hFF && pin_group_b_direction_o == 8'hFF
         && pin_group_a_direction_o == 5'h1F && s_reg.program_counter_high_latch == 5'h00)
      else $error("reset defaults not loaded");
   reset_gie_a: assert property ( // RL10
      ext_rst |=> !interrupt_control_o[7] ##1 ext_rst || !interrupt_control_o[7] || $past(bus_i.wr))
      else $error("global enable survived reset");
   service_a: assert property ( // RL11
      s_reg.mode == RWSI_RUN && !ext_rst && !watchdog_timer_timeout_i && !sleep_enter_i && global_interrupt_enable && wake_pending
         |=> vector_taken_s and return_addr_o == $past(pc_o))
      else $error("interrupt service sequence wrong");
   sleep_pd_a: assert property ( // RL12
      s_reg.mode == RWSI_RUN && sleep_enter_i && !ext_rst && !watchdog_timer_timeout_i
         |=> sleeping_o && cpu_status_flags_o[4:3] == 2'b10)
      else $error("sleep entry flags wrong");

   // Further checks per cause and between causes: nothing but the named cause may move these
   wdt_reset_regs_a: assert property ( // RL9
      !ext_rst && watchdog_timer_timeout_i && s_reg.mode != RWSI_SLEEP |=> pc_o == 13'h0000
         && option_settings_o == 8'hFF && pin_group_b_direction_o == 8'hFF
         && pin_group_a_direction_o == 5'h1F && s_reg.program_counter_high_latch == 5'h00)
      else $error("watchdog reset defaults not loaded");
   wdt_reset_gie_a: assert property ( // RL10
      !ext_rst && watchdog_timer_timeout_i && s_reg.mode != RWSI_SLEEP |=> !interrupt_control_o[7])
      else $error("global enable survived watchdog reset");
   ext_reset_interrupt_control_a: assert property ( // RL10
      ext_rst |=> interrupt_control_o[7:1] == 7'h00)
      else $error("control register not cleared by reset");
   wake_keeps_regs_a: assert property ( // RL9
      s_reg.mode == RWSI_SLEEP && !ext_rst && (watchdog_timer_timeout_i || wake_pending)
         |=> $stable(option_settings_o) && $stable(pin_group_a_direction_o)
         && $stable(pin_group_b_direction_o) && $stable(s_reg.program_counter_high_latch))
      else $error("wake-up changed a reset-only register");
   wdt_wake_run_a: assert property ( // RL5
      s_reg.mode == RWSI_SLEEP && !ext_rst && watchdog_timer_timeout_i
         |=> !sleeping_o && $stable(interrupt_control_o[7:3]))
      else $error("watchdog wake-up did not return to run");
   int_wake_run_a: assert property ( // RL3
      s_reg.mode == RWSI_SLEEP && !ext_rst && !watchdog_timer_timeout_i && wake_pending && !global_interrupt_enable
         |=> s_reg.mode == RWSI_RUN && !sleeping_o)
      else $error("interrupt wake-up without global enable did not run on");
   vec_wait_quiet_a: assert property ( // RL4
      s_reg.mode == RWSI_VEC_WAIT && s_reg.vec_cnt != 2'd3 && !ext_rst && !watchdog_timer_timeout_i && !bus_i.wr
         |=> !stack_push_o && $stable(pc_o))
      else $error("vector taken before the next instruction finished");
   sleep_hold_a: assert property ( // RL12
      s_reg.mode == RWSI_SLEEP && !ext_rst && !watchdog_timer_timeout_i && !wake_pending && !bus_i.wr
         |=> sleeping_o && $stable(pc_o) && $stable(cpu_status_flags_o))
      else $error("sleep left without a cause");
   push_pulse_a: assert property ( // RL11
      stack_push_o |=> !stack_push_o)
      else $error("stack push longer than one cycle");
   status_flags_ro_a: assert property ( // RL12
      s_reg.mode == RWSI_RUN && bus_i.wr && bus_i.addr == 8'h03 && !sleep_enter_i && !ext_rst
         && !watchdog_timer_timeout_i |=> cpu_status_flags_o[4:3] == $past(cpu_status_flags_o[4:3]))
      else $error("software changed the timeout or power-down flag");
   power_control_flags_read_a: assert property ( // RL8
      bus_i.rd && bus_i.addr == 8'h8E |=> rdata_o[7:2] == 6'h00 && !rdata_o[0])
      else $error("unimplemented power flag bits read as one");
   rdata_idle_a: assert property ( // RL8
      !bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data stood without a read");

endmodule : rwsi_reset_state

// ==== rwsi_sync2.sv ====
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
module rwsi_sync2 #(
   parameter int          W         = 1,
   parameter logic [W-1:0] RST_VAL  = '0
) (
   input  wire logic         ref_clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_reg <= RST_VAL;
         sync_o   <= RST_VAL;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule : rwsi_sync2

// ==== rwsi_testbench.sv ====
// Self-checking bench for the reset and wake-up state logic
`timescale 1ns/100ps
module testbench;
   import rwsi_pkg::*;

   logic          ref_clk_i;
   logic          reset_i;
   logic          external_reset_pin_n;
   logic          wd_timeout;
   logic          sleep_enter;
   logic          pc_step;
   logic [2:0]    int_flag_set;
   rwsi_bus_req_t bus;
   logic [7:0]    rdata;
   logic [12:0]   pc;
   logic [7:0]    status;
   logic [7:0]    interrupt_control;
   logic [7:0]    option;
   logic [4:0]    dira;
   logic [7:0]    dirb;
   logic          sleeping;
   logic          stack_push;
   logic [12:0]   return_addr;
   int            n_fail;
   int            cmp_count;
   int            k;
   // Each row: offset, write value, value read back
   logic [23:0]   rows [8] = '{24'h81_00_00, 24'h85_FF_1F, 24'h85_00_00, 24'h86_00_00,
                               24'h0A_FF_1F, 24'h8E_FF_02, 24'h30_AA_00, 24'h03_E5_FD};

   rwsi_reset_state dut (
      .ref_clk_i                (ref_clk_i),
      .reset_i                  (reset_i),
      .external_reset_pin_n_i   (external_reset_pin_n),
      .watchdog_timer_timeout_i (wd_timeout),
      .sleep_enter_i            (sleep_enter),
      .pc_step_i                (pc_step),
      .int_flag_set_i           (int_flag_set),
      .bus_i                    (bus),
      .rdata_o                  (rdata),
      .pc_o                     (pc),
      .cpu_status_flags_o       (status),
      .interrupt_control_o      (interrupt_control),
      .option_settings_o        (option),
      .pin_group_a_direction_o  (dira),
      .pin_group_b_direction_o  (dirb),
      .pin_group_a_data_o       (),
      .pin_group_b_data_o       (),
      .sleeping_o               (sleeping),
      .stack_push_o             (stack_push),
      .return_addr_o            (return_addr)
   );

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic finish_test;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pc

   // Every task starts just after an edge, so no input is assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      bus <= '0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      bus <= '0;
      #1;
      chk_reg(rdata, exp);
   endtask : rd

   // Bits: pc step, watchdog, sleep, interrupt flags 2:0
   task automatic pulse(input logic [5:0] v);
      @(posedge ref_clk_i);
      {pc_step, wd_timeout, sleep_enter, int_flag_set} <= v;
      @(posedge ref_clk_i);
      {pc_step, wd_timeout, sleep_enter, int_flag_set} <= 6'h00;
      #1;
   endtask : pulse

   // Pin held well past the two-flop synchroniser latency
   task automatic ext_rst;
      @(posedge ref_clk_i);
      external_reset_pin_n <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      external_reset_pin_n <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1;
   endtask : ext_rst

   initial begin
      #(25 * 5000);
      n_fail++;
      finish_test();
   end

   initial begin
      n_fail = 0;
      cmp_count = 0;
      reset_i = 1'b1;
      external_reset_pin_n = 1'b1;
      {pc_step, wd_timeout, sleep_enter, int_flag_set} = 6'h00;
      bus = '0;
      repeat (6) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      #1;
      chk_reg(status, 8'h18);
      chk_reg(option, 8'hFF);
      chk_reg({3'h0, dira}, 8'h1F);
      chk_reg(dirb, 8'hFF);
      chk_reg(interrupt_control, 8'h00);
      chk_pc(pc, 13'h0000);
      rd(8'h0A, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      // External reset while running
      wr(8'h0B, 8'h90);
      wr(8'h02, 8'h40);
      chk_pc(pc, 13'h1F40);
      pulse(6'h20);
      chk_pc(pc, 13'h1F41);
      ext_rst();
      chk_pc(pc, 13'h0000);
      chk_reg(status, 8'h1D);
      chk_reg(option, 8'hFF);
      chk_reg({3'h0, dira}, 8'h1F);
      chk_reg(dirb, 8'hFF);
      chk_reg(interrupt_control, 8'h00);
      rd(8'h0A, 8'h00);
      rd(8'h8E, 8'h02);
      // Watchdog reset while running
      wr(8'h81, 8'h00);
      pulse(6'h10);
      chk_reg(status, 8'h0D);
      chk_reg(option, 8'hFF);
      chk_pc(pc, 13'h0000);
      // Sleep, then watchdog wake-up
      wr(8'h81, 8'h00);
      wr(8'h02, 8'h20);
      pulse(6'h08);
      chk_reg({7'h00, sleeping}, 8'h01);
      chk_reg(status, 8'h15);
      pulse(6'h10);
      chk_pc(pc, 13'h0021);
      chk_reg(status, 8'h05);
      chk_reg(option, 8'h00);
      chk_reg({7'h00, sleeping}, 8'h00);
      // Interrupt wake-up with the global enable clear
      wr(8'h0B, 8'h10);
      pulse(6'h08);
      pulse(6'h02);
      // Flag lands at the pulse edge, the wake-up one edge later
      @(posedge ref_clk_i);
      #1;
      chk_pc(pc, 13'h0022);
      chk_reg(status, 8'h15);
      chk_reg(interrupt_control, 8'h12);
      // Interrupt wake-up with the global enable set
      wr(8'h0B, 8'h90);
      pulse(6'h08);
      pulse(6'h02);
      @(posedge ref_clk_i);
      #1;
      chk_pc(pc, 13'h0023);
      k = 0;
      while (stack_push !== 1'b1 && k < 20) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      if (k == 20) begin
         n_fail++;
         finish_test();
      end
      chk_pc(return_addr, 13'h0023);
      chk_pc(pc, 13'h0004);
      chk_reg(interrupt_control, 8'h12);
      // Service while running, raised by setting the global enable
      wr(8'h02, 8'h50);
      wr(8'h0B, 8'h92);
      @(posedge ref_clk_i);
      #1;
      chk_reg({7'h00, stack_push}, 8'h01);
      chk_pc(return_addr, 13'h0050);
      chk_pc(pc, 13'h0004);
      chk_reg(interrupt_control, 8'h12);
      // External reset during sleep
      wr(8'h0B, 8'h00);
      wr(8'h03, 8'hE0);
      pulse(6'h08);
      chk_reg(status, 8'hF0);
      ext_rst();
      chk_reg(status, 8'h10);
      chk_pc(pc, 13'h0000);
      chk_reg(option, 8'hFF);
      finish_test();
   end
endmodule : testbench
